// ---- logic/sps_page_stack.sv ----
`timescale 1ns/1ps
// How it works
// - Direct accesses to 0x80..0xFF go to SFR space, never to data memory.
// - Bit access is allowed only where the address low nibble is 0x0 or 0x8.
// - An 8-bit page select register picks which of 256 registers an address reaches.
// - Only pages 0x0, 0xC, 0xF and 0x10 carry implemented registers.
// - Interrupt entry pushes page into second entry and second into bottom at once.
// - In the same cycle as the push the page select is loaded with the interrupt's flag page.
// - Interrupt return pops the second entry back into the page select.
// - A pop copies bottom into second, and bottom reads 0x00 when nothing was pushed.
// - Software writes to stack entries change only that entry, never push or pop.
// - Vectoring selects page 0x00, 0x0C for CAN, 0x10 for the listed other sources.
// - The second entry is a full 8-bit read/write register.
// - The second entry sits at 0x85 on all pages and resets to zero.

// ---------------------------------------------------------------
// Behaviour at a glance
// ---------------------------------------------------------------
// Vectoring beats a return, and a return beats a core write.
// A core write to a stack register that meets an event in one cycle is lost.
// A pop leaves the bottom entry at zero, the empty reading.
// Page 0x10 counts as populated, since vectoring selects it.
// The three stack registers answer on every page.
// The bottom entry sits at 0x86 and the page select at 0xA7.
// Read data is registered and stands until the next read.
// Peripheral strobes are combinational, in the access cycle.
// Bit merging is the core's job; write data is a whole byte.
module sps_page_stack
    import sps_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Core direct access
    input wire logic acc_valid_i,
    input wire logic acc_direct_i,
    input wire logic acc_write_i,
    input wire logic acc_bit_i,
    input wire logic [7:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    // Interrupt events
    input wire logic irq_enter_i,
    input wire sps_src_t irq_src_i,
    input wire logic interrupt_return_instr_i,
    // Read data from peripherals
    input wire logic [7:0] periph_rdata_i,
    // Core read data and decode
    output logic [7:0] acc_rdata_o,
    output logic acc_sfr_o,
    output logic acc_bit_ok_o,
    output logic acc_bit_err_o,
    // Peripheral steering
    output logic periph_sel_o,
    output logic periph_write_o,
    output logic [7:0] periph_page_o,
    output logic [7:0] periph_addr_o,
    output logic [7:0] periph_wdata_o,
    output logic page_populated_o,
    // Stack state
    output logic [7:0] page_select_reg_o,
    output logic [7:0] page_stack_second_entry_o,
    output logic [7:0] page_stack_bottom_entry_o
);
    // ---------------------------------------------------------------
    // Stack storage
    // ---------------------------------------------------------------
    logic [7:0] page_select_reg;
    logic [7:0] page_stack_second_entry;
    logic [7:0] page_stack_bottom_entry;
    // Next values, worked out combinationally
    logic [7:0] next_page;
    logic [7:0] next_second;
    logic [7:0] next_bottom;
    // Flag page of the interrupt being vectored
    logic [7:0] vec_page;

    // Address decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    wire in_sfr;
    wire bit_ok;
    wire sfr_acc;
    wire wr;
    wire hit_page;
    wire hit_second;
    wire hit_bottom;
    wire hit_stack;
    wire populated;
    wire size_ok;
    wire rd_en;

    assign in_sfr = (acc_addr_i >= SPS_SFR_BASE) && (acc_addr_i <= SPS_SFR_TOP);
    assign sfr_acc = acc_valid_i && acc_direct_i && in_sfr;
    assign bit_ok = (acc_addr_i[3:0] == SPS_BIT_NIB_A) || (acc_addr_i[3:0] == SPS_BIT_NIB_B);
    // Byte access, or bit access on a bit-capable address
    assign size_ok = !acc_bit_i || bit_ok;
    // Bit write on a byte-only address is dropped
    assign wr = sfr_acc && acc_write_i && size_ok;
    // Reads capture on the taking edge
    assign rd_en = sfr_acc && !acc_write_i;
    assign hit_page = hit(acc_addr_i, SPS_ADDR_PAGE);
    assign hit_second = hit(acc_addr_i, SPS_ADDR_SECOND);
    assign hit_bottom = hit(acc_addr_i, SPS_ADDR_BOTTOM);
    assign hit_stack = hit_page || hit_second || hit_bottom;
    assign populated = (page_select_reg == SPS_PG_DEFAULT) || (page_select_reg == SPS_PG_CAN)
                       || (page_select_reg == SPS_PG_CFG) || (page_select_reg == SPS_PG_HIGH);

    // Vector page lookup
    // flag page per source
    sps_page_map u_map (
        .src_i(irq_src_i),
        .page_o(vec_page)
    );

    // ---------------------------------------------------------------
    // Next stack state
    // ---------------------------------------------------------------
    always_comb begin
        // Hold every entry unless an event or write moves it
        next_page = page_select_reg;
        next_second = page_stack_second_entry;
        next_bottom = page_stack_bottom_entry;
        // Vectoring has the highest priority
        if (irq_enter_i) begin
            next_second = page_select_reg;
            next_bottom = page_stack_second_entry;
            next_page = vec_page;
        end else if (interrupt_return_instr_i) begin
            next_page = page_stack_second_entry;
            next_second = page_stack_bottom_entry;
            next_bottom = SPS_RST_BOTTOM;
        end else if (wr) begin
            // Core write only when no event is due
            // write touches one entry only
            if (hit_page) begin
                next_page = acc_wdata_i;
            end
            if (hit_second) begin
                next_second = acc_wdata_i;
            end
            if (hit_bottom) begin
                next_bottom = acc_wdata_i;
            end
        end
    end

    // All three entries move together, so no access sees half a push
    // single-cycle update
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            page_select_reg <= SPS_RST_PAGE;
            page_stack_second_entry <= SPS_RST_SECOND;
            page_stack_bottom_entry <= SPS_RST_BOTTOM;
        end else begin
            page_select_reg <= next_page;
            page_stack_second_entry <= next_second;
            page_stack_bottom_entry <= next_bottom;
        end
    end

    // ---------------------------------------------------------------
    // Read data register
    // ---------------------------------------------------------------
    // Stack registers shadow the peripheral read data
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = periph_rdata_i;
        if (hit_page) begin
            rd_mux = page_select_reg;
        end else if (hit_second) begin
            rd_mux = page_stack_second_entry;
        end else if (hit_bottom) begin
            rd_mux = page_stack_bottom_entry;
        end
    end

    // Read data stands until the next read
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            acc_rdata_o <= 8'h00;
        end else if (rd_en) begin
            acc_rdata_o <= rd_mux;
        end
    end

    // ---------------------------------------------------------------
    // Steering outputs
    // ---------------------------------------------------------------
    // Core-side decode flags
    assign acc_sfr_o = sfr_acc;
    assign acc_bit_ok_o = sfr_acc && bit_ok;
    assign acc_bit_err_o = sfr_acc && acc_bit_i && !bit_ok;

    assign periph_sel_o = sfr_acc && !hit_stack && size_ok;
    assign periph_write_o = wr && !hit_stack;
    assign periph_page_o = page_select_reg;
    // Address and data pass straight through
    assign periph_addr_o = acc_addr_i;
    assign periph_wdata_o = acc_wdata_i;
    // populated flag for the current page
    assign page_populated_o = populated;

    // Stack state for observation
    assign page_select_reg_o = page_select_reg;
    assign page_stack_second_entry_o = page_stack_second_entry;
    assign page_stack_bottom_entry_o = page_stack_bottom_entry;
endmodule // sps_page_stack

// ---- logic/sps_pkg.sv ----
package sps_pkg;
    // ---------------------------------------------------------------
    // Address space
    // ---------------------------------------------------------------
    localparam logic [7:0] SPS_SFR_BASE = 8'h80;
    localparam logic [7:0] SPS_SFR_TOP = 8'hFF;
    localparam logic [3:0] SPS_BIT_NIB_A = 4'h0;
    localparam logic [3:0] SPS_BIT_NIB_B = 4'h8;
    // ---------------------------------------------------------------
    // Stack register offsets (reachable on all pages)
    // ---------------------------------------------------------------
    localparam logic [7:0] SPS_ADDR_SECOND = 8'h85;
    localparam logic [7:0] SPS_ADDR_BOTTOM = 8'h86;
    localparam logic [7:0] SPS_ADDR_PAGE = 8'hA7;
    // ---------------------------------------------------------------
    // Reset values and pages
    // ---------------------------------------------------------------
    localparam logic [7:0] SPS_RST_PAGE = 8'h00;
    localparam logic [7:0] SPS_RST_SECOND = 8'h00;
    localparam logic [7:0] SPS_RST_BOTTOM = 8'h00;
    localparam logic [7:0] SPS_PG_DEFAULT = 8'h00;
    localparam logic [7:0] SPS_PG_CAN = 8'h0C;
    localparam logic [7:0] SPS_PG_HIGH = 8'h10;
    localparam logic [7:0] SPS_PG_CFG = 8'h0F;
    // ---------------------------------------------------------------
    // Interrupt source classes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SPS_SRC_OTHER,
        SPS_SRC_CAN,
        SPS_SRC_SERIAL2,
        SPS_SRC_COUNTER2,
        SPS_SRC_COMP3,
        SPS_SRC_TIMER45
    } sps_src_t;
endpackage

// ---- logic/sps_page_map.sv ----
`timescale 1ns/1ps
// Maps an interrupt source class to the page holding its flag
module sps_page_map
    import sps_pkg::*;
(
    // Source
    input wire sps_src_t src_i,
    // Page
    output logic [7:0] page_o
);
    // ---------------------------------------------------------------
    // Vector page lookup
    // ---------------------------------------------------------------
    always_comb begin
        case (src_i)
            SPS_SRC_CAN: page_o = SPS_PG_CAN;
            SPS_SRC_SERIAL2, SPS_SRC_COUNTER2, SPS_SRC_COMP3, SPS_SRC_TIMER45: page_o = SPS_PG_HIGH;
            default: page_o = SPS_PG_DEFAULT;
        endcase
    end
endmodule // sps_page_map

// ---- testbench/sps_periph_model.sv ----
`timescale 1ns/1ps
// Peripheral side of the steered access
module sps_periph_model (
    // Steered access
    input wire logic sel_i,
    input wire logic [7:0] page_i,
    input wire logic [7:0] addr_i,
    // Read data back
    output logic [7:0] rdata_o
);
    // Deselected bus shows the inverse, never a stale value
    assign rdata_o = sel_i ? (page_i ^ addr_i) : ~(page_i ^ addr_i);
endmodule // sps_periph_model

// ---- testbench/sps_page_stack_properties.sv ----
`timescale 1ns/1ps
module sps_page_stack_chk
    import sps_pkg::*;
(
    input wire logic ref_clk_i, rst_b_i, acc_valid_i, acc_direct_i, acc_write_i, acc_bit_i,
    input wire logic [7:0] acc_addr_i, acc_wdata_i, acc_rdata_o, periph_page_o,
    input wire logic irq_enter_i, interrupt_return_instr_i, acc_sfr_o, acc_bit_ok_o,
    input wire sps_src_t irq_src_i,
    input wire logic acc_bit_err_o, periph_sel_o, periph_write_o,
    input wire logic [7:0] periph_addr_o, periph_wdata_o,
    input wire logic [7:0] page_select_reg_o, page_stack_second_entry_o, page_stack_bottom_entry_o
);
    // Short aliases and event decode
    wire [7:0] pg = page_select_reg_o;
    wire [7:0] nx = page_stack_second_entry_o;
    wire [7:0] lt = page_stack_bottom_entry_o;
    wire ev = irq_enter_i | interrupt_return_instr_i;
    wire sw = acc_sfr_o & acc_write_i & !acc_bit_i & !ev;
    // Stack registers and legal access size, from the address alone
    wire stk_hit = (acc_addr_i == SPS_ADDR_PAGE) | (acc_addr_i == SPS_ADDR_SECOND)
                   | (acc_addr_i == SPS_ADDR_BOTTOM);
    wire size_ok = !acc_bit_i | (acc_addr_i[2:0] == 3'h0);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    sfr_decode_a: assert property (acc_sfr_o == (acc_valid_i & acc_direct_i & acc_addr_i[7]))
        else $error("sfr decode wrong");
    bit_nibble_a: assert property (acc_bit_ok_o == (acc_sfr_o & acc_addr_i[2:0] == 3'h0))
        else $error("bit access decode wrong");
    stack_push_a: assert property (irq_enter_i |=> nx == $past(pg) && lt == $past(nx))
        else $error("push wrong");
    can_page_a: assert property (irq_enter_i && irq_src_i == SPS_SRC_CAN |=> pg == SPS_PG_CAN)
        else $error("vector page wrong");
    stack_pop_a: assert property (interrupt_return_instr_i && !irq_enter_i |=> pg == $past(nx) && nx == $past(lt) && lt == 8'h00)
        else $error("pop wrong");
    sw_write_a: assert property (sw && acc_addr_i == SPS_ADDR_SECOND |=> nx == $past(acc_wdata_i) && $stable(pg) && $stable(lt))
        else $error("second entry write wrong");
    read_back_a: assert property (acc_sfr_o && !acc_write_i && acc_addr_i == SPS_ADDR_SECOND |=> acc_rdata_o == $past(nx))
        else $error("second entry read wrong");
    stack_hold_a: assert property (!ev && !sw |=> $stable(nx) && $stable(lt))
        else $error("stack moved without event");
    page_out_a: assert property (periph_page_o == pg)
        else $error("steering page wrong");
    bit_error_a: assert property (acc_bit_err_o == (acc_sfr_o & acc_bit_i & (acc_addr_i[2:0] != 3'h0)))
        else $error("bit error flag wrong");
    periph_select_a: assert property (periph_sel_o == (acc_sfr_o & size_ok & !stk_hit))
        else $error("peripheral select wrong");
    periph_write_a: assert property (periph_write_o == (acc_sfr_o & acc_write_i & size_ok & !stk_hit))
        else $error("peripheral write wrong");
    periph_pass_a: assert property (periph_addr_o == acc_addr_i && periph_wdata_o == acc_wdata_i)
        else $error("peripheral address or data wrong");
endmodule // sps_page_stack_chk
bind sps_page_stack sps_page_stack_chk u_chk (.*);

// ---- testbench/sps_page_stack_tb.sv ----
`timescale 1ns/1ps
module sps_page_stack_tb;
    import sps_pkg::*;
    logic ref_clk_i = 1'b0, rst_b_i = 1'b0, acc_valid_i = 1'b0, acc_direct_i = 1'b0, acc_write_i = 1'b0;
    logic acc_bit_i = 1'b0, irq_enter_i = 1'b0, interrupt_return_instr_i = 1'b0;
    logic [7:0] acc_addr_i = 8'h00, acc_wdata_i = 8'h00, periph_rdata_i, acc_rdata_o, periph_page_o;
    logic [7:0] periph_addr_o, periph_wdata_o, page_select_reg_o, page_stack_second_entry_o;
    logic [7:0] page_stack_bottom_entry_o, pv, nv, tv;
    logic acc_sfr_o, acc_bit_ok_o, acc_bit_err_o, periph_sel_o, periph_write_o, page_populated_o;
    logic [2:0] fl;
    sps_src_t irq_src_i = SPS_SRC_OTHER;
    int num_errors = 0, checks_done = 0;
    sps_page_stack dut (.*);
    sps_periph_model prt (.sel_i(periph_sel_o), .page_i(periph_page_o), .addr_i(periph_addr_o),
        .rdata_o(periph_rdata_i));
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stk(input logic [7:0] p, input logic [7:0] n, input logic [7:0] l);
        chk(page_select_reg_o, p);
        chk(page_stack_second_entry_o, n);
        chk(page_stack_bottom_entry_o, l);
    endtask
    // One core cycle, f = {valid, write, bit, enter, return}
    task automatic op(input logic [4:0] f, input logic [7:0] a, input logic [7:0] d,
        input sps_src_t s = SPS_SRC_OTHER, input logic dr = 1'b1);
        @(posedge ref_clk_i);
        {acc_valid_i, acc_write_i, acc_bit_i, irq_enter_i, interrupt_return_instr_i} <= f;
        acc_direct_i <= dr;
        acc_addr_i <= a;
        acc_wdata_i <= d;
        irq_src_i <= s;
        #1 fl = {acc_sfr_o, acc_bit_ok_o, acc_bit_err_o};
        @(posedge ref_clk_i);
        {acc_valid_i, acc_write_i, acc_bit_i, irq_enter_i, interrupt_return_instr_i} <= 5'h00;
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #5000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        #1 stk(8'h00, 8'h00, 8'h00);
        op(5'h18, SPS_ADDR_PAGE, SPS_PG_CFG);
        op(5'h18, SPS_ADDR_SECOND, 8'h5A);
        op(5'h18, SPS_ADDR_BOTTOM, 8'h33);
        stk(SPS_PG_CFG, 8'h5A, 8'h33);
        op(5'h10, SPS_ADDR_SECOND, 8'h00);
        chk(acc_rdata_o, 8'h5A);
        op(5'h1C, SPS_ADDR_SECOND, 8'hC3);
        chk({5'h00, fl}, 8'h05);
        chk(page_stack_second_entry_o, 8'h5A);
        op(5'h14, 8'h88, 8'h00);
        chk({5'h00, fl}, 8'h06);
        op(5'h18, SPS_ADDR_SECOND, 8'hEE, SPS_SRC_OTHER, 1'b0);
        chk({5'h00, fl}, 8'h00);
        chk(page_stack_second_entry_o, 8'h5A);
        op(5'h10, 8'hA0, 8'h00);
        chk(acc_rdata_o, SPS_PG_CFG ^ 8'hA0);
        chk({7'h00, page_populated_o}, 8'h01);
        op(5'h18, 8'hA0, 8'h3C);
        stk(SPS_PG_CFG, 8'h5A, 8'h33);
        pv = SPS_PG_CFG;
        nv = 8'h5A;
        for (int i = 2; i < 8; i++) begin
            op(5'h02, 8'h00, 8'h00, sps_src_t'(i % 6));
            tv = (i % 6 == 0) ? SPS_PG_DEFAULT : (i % 6 == 1) ? SPS_PG_CAN : SPS_PG_HIGH;
            stk(tv, pv, nv);
            nv = pv;
            pv = tv;
        end
        op(5'h01, 8'h00, 8'h00);
        stk(SPS_PG_DEFAULT, SPS_PG_HIGH, 8'h00);
        op(5'h18, SPS_ADDR_SECOND, SPS_PG_CFG);
        op(5'h01, 8'h00, 8'h00);
        stk(SPS_PG_CFG, 8'h00, 8'h00);
        op(5'h1A, SPS_ADDR_SECOND, 8'h77, SPS_SRC_CAN);
        stk(SPS_PG_CAN, SPS_PG_CFG, 8'h00);
        op(5'h18, SPS_ADDR_PAGE, 8'h05);
        chk({7'h00, page_populated_o}, 8'h00);
        end_sim();
    end
endmodule // sps_page_stack_tb
